// ===== hdl/lcd_cmd_pkg.sv
// Constants, command encodings, reset values and types of the LCD command and address logic
// How it works
// - Write command 011xxxxx loads low nibble as density, 0 lightest, 15 darkest.
// - Reset sets density to the lightest level, code 60 hex.
// - Every density write sets booster enable from bit D4.
// - Booster stays disabled after reset until software enables it.
// - 11 hex enables, 10 hex disables oscillator; disabled oscillator stops internal timing.
// - Oscillator run enable is set after reset.
// - 20 hex selects external clock, 21 hex RC oscillator; 22/23 hex forbidden.
// - Reset selects external clock supply mode.
// - 40..43 hex select booster clock: half, quarter, eighth, full oscillator rate.
// - Reset selects half oscillator rate for booster clock.
// - Instruction read returns status: word length, display on, in reset, counter, direction.
// - Status flags read 1 for 8-bit, on, page counter, up; else 0.
// - In-reset flag reads 1 during reset and 0 after release.
// - Data write stores byte at current address; data read returns stored byte.
// - Column up mode increments per access, 17 wraps to 0.
// - Column down mode decrements per access, 0 wraps to 17.
// - Column counter selected leaves the page unchanged on data accesses.
// - 8-bit mode page counter steps up/down, wrapping between 9 and 0.
// - Page counter selected leaves the column unchanged on data accesses.
// - 6-bit mode page counter wraps between 13 and 0.
// - Reset: standby, 1/16 duty, 8-bit, page up, page 0, column 0, defaults.
// - Frame rate is oscillator divided by 432 at 1/18, 384 at 1/16 duty.
// - 80..83 hex select column down, column up, page down, page up.
// - C0..D1 hex load column 0..17 from low five bits.
// - E0..EF hex load page from low four bits.
// - Word length/duty command: D1 8-bit when 1, D0 1/18 duty when 1.
package lcd_cmd_pkg;
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int RC_FREQ_HZ = 33_000;
    localparam int RC_DIV_CYCLES = CLK_FREQ_HZ / RC_FREQ_HZ;
    localparam int RC_DIV_W = 10;
    localparam int FRAME_DIV_W = 9;
    localparam int PUMP_DIV_W = 4;
    localparam logic [FRAME_DIV_W-1:0] FRAME_DIV_18 = 9'h1b0;
    localparam logic [FRAME_DIV_W-1:0] FRAME_DIV_16 = 9'h180;
    localparam logic [PUMP_DIV_W-1:0] PUMP_DIV_HALF = 4'h2;
    localparam logic [PUMP_DIV_W-1:0] PUMP_DIV_QUARTER = 4'h4;
    localparam logic [PUMP_DIV_W-1:0] PUMP_DIV_EIGHTH = 4'h8;
    localparam logic [PUMP_DIV_W-1:0] PUMP_DIV_FULL = 4'h1;
    localparam logic [1:0] PUMP_SEL_HALF = 2'h0;
    localparam logic [1:0] PUMP_SEL_QUARTER = 2'h1;
    localparam logic [1:0] PUMP_SEL_EIGHTH = 2'h2;
    localparam logic [1:0] PUMP_SEL_FULL = 2'h3;
    localparam int COL_W = 5;
    localparam int PAGE_W = 4;
    localparam int DENSITY_W = 4;
    localparam int RAM_AW = PAGE_W + COL_W;
    localparam logic [COL_W-1:0] COL_MAX = 5'h11;
    localparam logic [PAGE_W-1:0] PAGE_MAX_8BIT = 4'h9;
    localparam logic [PAGE_W-1:0] PAGE_MAX_6BIT = 4'hd;
    localparam logic [7:0] CMD_DISP_STANDBY = 8'h00;
    localparam logic [7:0] CMD_DISP_OFF = 8'h01;
    localparam logic [7:0] CMD_DISP_ON = 8'h03;
    localparam logic [7:0] CMD_WLD_BASE = 8'h08;
    localparam logic [7:0] CMD_WLD_MASK = 8'hfc;
    localparam logic [7:0] CMD_OSC_OFF = 8'h10;
    localparam logic [7:0] CMD_OSC_ON = 8'h11;
    localparam logic [7:0] CMD_SRC_EXT = 8'h20;
    localparam logic [7:0] CMD_SRC_RC = 8'h21;
    localparam logic [7:0] CMD_PUMP_BASE = 8'h40;
    localparam logic [7:0] CMD_PUMP_MASK = 8'hfc;
    localparam logic [7:0] CMD_DENSITY_BASE = 8'h60;
    localparam logic [7:0] CMD_DENSITY_MASK = 8'he0;
    localparam logic [7:0] CMD_CNT_BASE = 8'h80;
    localparam logic [7:0] CMD_CNT_MASK = 8'hfc;
    localparam logic [7:0] CMD_COL_BASE = 8'hc0;
    localparam logic [7:0] CMD_COL_MASK = 8'he0;
    localparam logic [7:0] CMD_PAGE_BASE = 8'he0;
    localparam logic [7:0] CMD_PAGE_MASK = 8'hf0;
    localparam int BOOSTER_BIT = 4;
    localparam int WLEN_BIT = 1;
    localparam int DUTY_BIT = 0;
    localparam int CSEL_BIT = 1;
    localparam int DIR_BIT = 0;
    localparam logic [DENSITY_W-1:0] RST_DENSITY = 4'h0;
    localparam logic RST_BOOSTER = 1'b0;
    localparam logic RST_OSC_RUN = 1'b1;
    localparam logic RST_SRC_RC = 1'b0;
    localparam logic [1:0] RST_PUMP_SEL = PUMP_SEL_HALF;
    localparam logic RST_WLEN_8BIT = 1'b1;
    localparam logic RST_DUTY_18 = 1'b0;
    localparam logic RST_CSEL_PAGE = 1'b1;
    localparam logic RST_COUNT_UP = 1'b1;
    localparam logic RST_STANDBY = 1'b1;
    localparam logic RST_DISP_ON = 1'b0;
    localparam logic [COL_W-1:0] RST_COL = 5'h00;
    localparam logic [PAGE_W-1:0] RST_PAGE = 4'h0;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_FETCH = 3'b010,
        BUS_HOLD = 3'b100
    } bus_state_e;
endpackage

// ===== hdl/rate_divider.sv
// Tick divider: emits one pulse per divisor input ticks
`timescale 1ns/1ps
module rate_divider #(
    parameter int W = 9
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic tick_in,
    input wire logic [W-1:0] divisor,
    output logic tick_out
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (tick_in) begin
            if (cnt_ff >= divisor - 1'b1) begin
                nxt_cnt = '0;
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_out = tick_ff;
endmodule // rate_divider

// ===== hdl/pixel_ram.sv
// Display RAM with registered read port
`timescale 1ns/1ps
module pixel_ram #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rdata_ff;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        if (rd_en) begin
            rdata_ff <= mem[addr];
        end
    end

    assign rdata = rdata_ff;
endmodule // pixel_ram

// ===== hdl/lcd_command_and_address_logic.sv
// Command decoder, status read, display RAM addressing and timing division
`timescale 1ns/1ps
module lcd_command_and_address_logic
    import lcd_cmd_pkg::*;
#(
    parameter int RC_DIV = RC_DIV_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce_n_pin,
    input wire logic rw_pin,
    input wire logic di_pin,
    input wire logic [7:0] data_in_pin,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic ext_clk_pin,
    output logic [DENSITY_W-1:0] density_level,
    output logic booster_enable,
    output logic osc_run,
    output logic clk_source_rc,
    output logic [1:0] pump_clk_sel,
    output logic display_standby_bit,
    output logic display_on_flag,
    output logic duty_18,
    output logic word_length_flag,
    output logic counter_sel_page,
    output logic count_up,
    output logic [COL_W-1:0] column_addr,
    output logic [PAGE_W-1:0] page_addr,
    output logic frame_tick,
    output logic pump_tick
);
    // Pin synchronisers: chip enable, rw, di, external clock and data through two flip-flops
    logic [11:0] pins_s1_ff, pins_s2_ff, nxt_pins_s1, nxt_pins_s2;
    logic ce_s2_ff, rw_s2_ff, di_s2_ff, ext_s2_ff, ce_prev_ff, ext_prev_ff, nxt_ce_prev, nxt_ext_prev;
    logic [7:0] d_s2_ff;

    assign {ce_s2_ff, rw_s2_ff, di_s2_ff, ext_s2_ff, d_s2_ff} = pins_s2_ff;

    always_comb begin
        nxt_pins_s1 = {ce_n_pin, rw_pin, di_pin, ext_clk_pin, data_in_pin};
        nxt_pins_s2 = pins_s1_ff;
        nxt_ce_prev = ce_s2_ff;
        nxt_ext_prev = ext_s2_ff;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pins_s1_ff <= 12'h800;
            pins_s2_ff <= 12'h800;
            ce_prev_ff <= 1'b1;
            ext_prev_ff <= 1'b0;
        end else begin
            pins_s1_ff <= nxt_pins_s1;
            pins_s2_ff <= nxt_pins_s2;
            ce_prev_ff <= nxt_ce_prev;
            ext_prev_ff <= nxt_ext_prev;
        end
    end

    // Bus access sequencing
    bus_state_e bus_st_ff, nxt_bus_st;
    logic rw_acc_ff, di_acc_ff, nxt_rw_acc, nxt_di_acc;
    logic [7:0] data_out_ff, nxt_data_out;
    logic data_oe_ff, nxt_data_oe;
    logic in_reset_ff;
    logic ce_fall, release_acc, cmd_wr, data_step, ram_wr, ram_rd;
    logic [7:0] ram_q, status_byte, cmd;

    logic [DENSITY_W-1:0] density_lvl_ff, nxt_density_lvl;
    logic booster_en_ff, nxt_booster_en, osc_run_ff, nxt_osc_run, src_rc_ff, nxt_src_rc;
    logic [1:0] pump_sel_ff, nxt_pump_sel;
    logic standby_ff, nxt_standby, disp_on_ff, nxt_disp_on, duty18_ff, nxt_duty18;
    logic wlen8_ff, nxt_wlen8, csel_page_ff, nxt_csel_page, up_ff, nxt_up;
    logic [COL_W-1:0] col_ff, nxt_col;
    logic [PAGE_W-1:0] page_ff, nxt_page, page_max;

    assign cmd = d_s2_ff;
    assign ce_fall = ce_prev_ff && !ce_s2_ff;
    assign release_acc = (bus_st_ff == BUS_HOLD) && ce_s2_ff;
    assign cmd_wr = release_acc && !rw_acc_ff && !di_acc_ff;
    assign data_step = release_acc && di_acc_ff;
    assign ram_wr = release_acc && !rw_acc_ff && di_acc_ff;
    assign ram_rd = (bus_st_ff == BUS_IDLE) && ce_fall && rw_s2_ff && di_s2_ff;
    assign page_max = wlen8_ff ? PAGE_MAX_8BIT : PAGE_MAX_6BIT;
    assign status_byte = {1'b0, wlen8_ff, disp_on_ff, in_reset_ff, 2'b00, csel_page_ff, up_ff};

    always_comb begin
        nxt_bus_st = bus_st_ff;
        nxt_rw_acc = rw_acc_ff;
        nxt_di_acc = di_acc_ff;
        nxt_data_out = data_out_ff;
        nxt_data_oe = data_oe_ff;
        case (bus_st_ff)
            BUS_IDLE: begin
                if (ce_fall) begin
                    nxt_rw_acc = rw_s2_ff;
                    nxt_di_acc = di_s2_ff;
                    if (rw_s2_ff && di_s2_ff) begin
                        nxt_bus_st = BUS_FETCH;
                    end else begin
                        if (rw_s2_ff) begin
                            nxt_data_out = status_byte;
                            nxt_data_oe = 1'b1;
                        end
                        nxt_bus_st = BUS_HOLD;
                    end
                end
            end
            BUS_FETCH: begin
                nxt_data_out = ram_q;
                nxt_data_oe = 1'b1;
                nxt_bus_st = BUS_HOLD;
            end
            BUS_HOLD: begin
                if (ce_s2_ff) begin
                    nxt_data_oe = 1'b0;
                    nxt_bus_st = BUS_IDLE;
                end
            end
            default: begin
                nxt_data_oe = 1'b0;
                nxt_bus_st = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_st_ff <= BUS_IDLE;
            rw_acc_ff <= 1'b0;
            di_acc_ff <= 1'b0;
            data_out_ff <= 8'h00;
            data_oe_ff <= 1'b0;
            in_reset_ff <= 1'b1;
        end else begin
            bus_st_ff <= nxt_bus_st;
            rw_acc_ff <= nxt_rw_acc;
            di_acc_ff <= nxt_di_acc;
            data_out_ff <= nxt_data_out;
            data_oe_ff <= nxt_data_oe;
            in_reset_ff <= 1'b0;
        end
    end

    // Settings and address counters
    always_comb begin
        nxt_density_lvl = density_lvl_ff;
        nxt_booster_en = booster_en_ff;
        nxt_osc_run = osc_run_ff;
        nxt_src_rc = src_rc_ff;
        nxt_pump_sel = pump_sel_ff;
        nxt_standby = standby_ff;
        nxt_disp_on = disp_on_ff;
        nxt_duty18 = duty18_ff;
        nxt_wlen8 = wlen8_ff;
        nxt_csel_page = csel_page_ff;
        nxt_up = up_ff;
        nxt_col = col_ff;
        nxt_page = page_ff;
        if (cmd_wr) begin
            if (cmd == CMD_DISP_STANDBY) begin
                nxt_standby = 1'b1;
                nxt_disp_on = 1'b0;
            end else if (cmd == CMD_DISP_OFF || cmd == CMD_DISP_ON) begin
                nxt_standby = 1'b0;
                nxt_disp_on = (cmd == CMD_DISP_ON);
            end else if ((cmd & CMD_WLD_MASK) == CMD_WLD_BASE) begin
                nxt_wlen8 = cmd[WLEN_BIT];
                nxt_duty18 = cmd[DUTY_BIT];
            end else if (cmd == CMD_OSC_ON || cmd == CMD_OSC_OFF) begin
                nxt_osc_run = (cmd == CMD_OSC_ON);
            end else if (cmd == CMD_SRC_EXT || cmd == CMD_SRC_RC) begin
                nxt_src_rc = (cmd == CMD_SRC_RC);
            end else if ((cmd & CMD_PUMP_MASK) == CMD_PUMP_BASE) begin
                nxt_pump_sel = cmd[1:0];
            end else if ((cmd & CMD_DENSITY_MASK) == CMD_DENSITY_BASE) begin
                nxt_density_lvl = cmd[DENSITY_W-1:0];
                nxt_booster_en = cmd[BOOSTER_BIT];
            end else if ((cmd & CMD_CNT_MASK) == CMD_CNT_BASE) begin
                nxt_csel_page = cmd[CSEL_BIT];
                nxt_up = cmd[DIR_BIT];
            end else if ((cmd & CMD_COL_MASK) == CMD_COL_BASE) begin
                if (cmd[COL_W-1:0] <= COL_MAX) begin
                    nxt_col = cmd[COL_W-1:0];
                end
            end else if ((cmd & CMD_PAGE_MASK) == CMD_PAGE_BASE) begin
                nxt_page = cmd[PAGE_W-1:0];
            end
            // Any other byte falls through with every setting held
        end else if (data_step) begin
            if (!csel_page_ff) begin
                // Page held while the column counter runs
                if (up_ff) begin
                    nxt_col = (col_ff >= COL_MAX) ? '0 : col_ff + 1'b1;
                end else begin
                    nxt_col = (col_ff == '0) ? COL_MAX : col_ff - 1'b1;
                end
            end else begin
                // Column held while the page counter runs
                if (up_ff) begin
                    nxt_page = (page_ff >= page_max) ? '0 : page_ff + 1'b1;
                end else begin
                    nxt_page = (page_ff == '0) ? page_max : page_ff - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            density_lvl_ff <= RST_DENSITY;
            booster_en_ff <= RST_BOOSTER;
            osc_run_ff <= RST_OSC_RUN;
            src_rc_ff <= RST_SRC_RC;
            pump_sel_ff <= RST_PUMP_SEL;
            standby_ff <= RST_STANDBY;
            disp_on_ff <= RST_DISP_ON;
            duty18_ff <= RST_DUTY_18;
            wlen8_ff <= RST_WLEN_8BIT;
            csel_page_ff <= RST_CSEL_PAGE;
            up_ff <= RST_COUNT_UP;
            col_ff <= RST_COL;
            page_ff <= RST_PAGE;
        end else begin
            density_lvl_ff <= nxt_density_lvl;
            booster_en_ff <= nxt_booster_en;
            osc_run_ff <= nxt_osc_run;
            src_rc_ff <= nxt_src_rc;
            pump_sel_ff <= nxt_pump_sel;
            standby_ff <= nxt_standby;
            disp_on_ff <= nxt_disp_on;
            duty18_ff <= nxt_duty18;
            wlen8_ff <= nxt_wlen8;
            csel_page_ff <= nxt_csel_page;
            up_ff <= nxt_up;
            col_ff <= nxt_col;
            page_ff <= nxt_page;
        end
    end

    pixel_ram #(.AW(RAM_AW), .DW(8)) u_ram (
        .clk(clk),
        .wr_en(ram_wr),
        .rd_en(ram_rd),
        .addr({page_ff, col_ff}),
        .wdata(cmd),
        .rdata(ram_q)
    );

    // Oscillator tick, frame and booster clock division
    logic rc_tick, osc_tick, ext_rise;
    logic [FRAME_DIV_W-1:0] frame_div;
    logic [PUMP_DIV_W-1:0] pump_div;

    assign ext_rise = ext_s2_ff && !ext_prev_ff;
    assign osc_tick = osc_run_ff && (src_rc_ff ? rc_tick : ext_rise);
    assign frame_div = duty18_ff ? FRAME_DIV_18 : FRAME_DIV_16;

    always_comb begin
        case (pump_sel_ff)
            PUMP_SEL_HALF: pump_div = PUMP_DIV_HALF;
            PUMP_SEL_QUARTER: pump_div = PUMP_DIV_QUARTER;
            PUMP_SEL_EIGHTH: pump_div = PUMP_DIV_EIGHTH;
            PUMP_SEL_FULL: pump_div = PUMP_DIV_FULL;
            default: pump_div = PUMP_DIV_HALF;
        endcase
    end

    rate_divider #(.W(RC_DIV_W)) u_rc_div (
        .clk(clk),
        .srst(srst),
        .tick_in(osc_run_ff && src_rc_ff),
        .divisor(RC_DIV_W'(RC_DIV)),
        .tick_out(rc_tick)
    );

    rate_divider #(.W(FRAME_DIV_W)) u_frame_div (
        .clk(clk),
        .srst(srst),
        .tick_in(osc_tick),
        .divisor(frame_div),
        .tick_out(frame_tick)
    );

    rate_divider #(.W(PUMP_DIV_W)) u_pump_div (
        .clk(clk),
        .srst(srst),
        .tick_in(osc_tick && booster_en_ff),
        .divisor(pump_div),
        .tick_out(pump_tick)
    );

    assign data_out = data_out_ff;
    assign data_oe = data_oe_ff;
    assign density_level = density_lvl_ff;
    assign booster_enable = booster_en_ff;
    assign osc_run = osc_run_ff;
    assign clk_source_rc = src_rc_ff;
    assign pump_clk_sel = pump_sel_ff;
    assign display_standby_bit = standby_ff;
    assign display_on_flag = disp_on_ff;
    assign duty_18 = duty18_ff;
    assign word_length_flag = wlen8_ff;
    assign counter_sel_page = csel_page_ff;
    assign count_up = up_ff;
    assign column_addr = col_ff;
    assign page_addr = page_ff;

    density_load_a: assert property (@(posedge clk) disable iff (srst)
        (cmd_wr && cmd[7:5] == 3'b011) |=> density_level == $past(cmd[3:0]))
        else $error("density level not loaded");
    booster_write_a: assert property (@(posedge clk) disable iff (srst)
        (cmd_wr && cmd[7:5] == 3'b011) |=> booster_enable == $past(cmd[4]))
        else $error("booster enable not taken from D4");
    reset_defaults_a: assert property (@(posedge clk)
        srst |=> (density_level == 4'h0 && !booster_enable && osc_run && !clk_source_rc && pump_clk_sel == 2'h0
        && display_standby_bit && !duty_18 && word_length_flag && counter_sel_page && count_up
        && column_addr == 5'h00 && page_addr == 4'h0))
        else $error("reset defaults wrong");
    osc_stop_a: assert property (@(posedge clk) disable iff (srst)
        (!osc_run)[*3] |-> (!pump_tick && !frame_tick))
        else $error("timing ticks while oscillator stopped");
    forbidden_src_a: assert property (@(posedge clk) disable iff (srst)
        (cmd_wr && cmd != CMD_SRC_EXT && cmd != CMD_SRC_RC) |=> $stable(clk_source_rc))
        else $error("clock source changed by another command");
    status_read_a: assert property (@(posedge clk) disable iff (srst)
        (bus_st_ff == BUS_IDLE && ce_fall && rw_s2_ff && !di_s2_ff) |=>
        (data_oe && data_out == {1'b0, word_length_flag, display_on_flag, 2'b00, 1'b0, counter_sel_page, count_up}))
        else $error("status byte wrong");
    in_reset_flag_a: assert property (@(posedge clk)
        !srst ##1 !srst |-> !in_reset_ff)
        else $error("in-reset flag stuck after release");
    col_wrap_up_a: assert property (@(posedge clk) disable iff (srst)
        (data_step && !counter_sel_page && count_up && column_addr == 5'h11) |=> column_addr == 5'h00)
        else $error("column up wrap wrong");
    col_wrap_down_a: assert property (@(posedge clk) disable iff (srst)
        (data_step && !counter_sel_page && !count_up && column_addr == 5'h00) |=> column_addr == 5'h11)
        else $error("column down wrap wrong");
    page_held_a: assert property (@(posedge clk) disable iff (srst)
        (data_step && !counter_sel_page) |=> $stable(page_addr))
        else $error("page moved while column counter selected");
    page_wrap_a: assert property (@(posedge clk) disable iff (srst)
        (data_step && counter_sel_page && !count_up && page_addr == 4'h0) |=>
        page_addr == (word_length_flag ? 4'h9 : 4'hd))
        else $error("page down wrap wrong");
    column_held_a: assert property (@(posedge clk) disable iff (srst)
        (data_step && counter_sel_page) |=> $stable(column_addr))
        else $error("column moved while page counter selected");
    undefined_cmd_a: assert property (@(posedge clk) disable iff (srst)
        (cmd_wr && (cmd == 8'h02 || cmd == 8'h30)) |=> ($stable(density_level) && $stable(osc_run)
        && $stable(column_addr) && $stable(page_addr) && $stable(display_on_flag)))
        else $error("undefined command changed state");
endmodule // lcd_command_and_address_logic

// ===== verif/mpu_host.sv
// Host processor model driving the byte-wide access bus
`timescale 1ns/1ps
module mpu_host (
    input wire logic clk,
    input wire logic [7:0] rd_bus,
    input wire logic rd_oe,
    output logic ce_n,
    output logic rw,
    output logic di,
    output logic [7:0] wr_bus
);
    initial begin
        ce_n = 1'b1;
        rw = 1'b1;
        di = 1'b0;
        wr_bus = 8'h00;
    end
    // Select low 6 clk, data kept 1 clk past release, then 4 clk idle
    task automatic access(input logic r, input logic d, input logic [7:0] w, output logic [7:0] q);
        @(posedge clk) #1;
        ce_n = 1'b0;
        rw = r;
        di = d;
        wr_bus = w;
        repeat (6) @(posedge clk);
        // A released bus reads back inverted, so a missing output enable shows up
        q = rd_oe ? rd_bus : ~rd_bus;
        #1 ce_n = 1'b1;
        @(posedge clk) #1;
        wr_bus = ~w;
        repeat (3) @(posedge clk);
        #1;
    endtask
endmodule // mpu_host

// ===== verif/lcd_command_and_address_logic_tb_top.sv
// Self-checking bench of the LCD command and address logic
`timescale 1ns/1ps
module lcd_command_and_address_logic_tb_top;
    import lcd_cmd_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ext_clk = 1'b0;
    localparam int RC_TB = 4;
    logic ce_n, rw, di, boost, osc, src, stby, on, duty, wlen, csel, up, oe, ftick, ptick;
    logic [7:0] wbus, rbus, q;
    logic [3:0] density, page;
    logic [4:0] col;
    logic [1:0] pump;
    int bad_count = 0;
    int compares = 0;
    int fgap = 0, fper = 0, pgap = 0, pper = 0;
    wire [14:0] cfg = {density, boost, osc, src, pump, stby, on, duty, wlen, csel, up};
    wire [8:0] addr = {page, col};
    always #20 clk = ~clk;
    always begin
        repeat (375) @(posedge clk);
        #1 ext_clk = ~ext_clk;
    end
    // Cycles between consecutive frame and booster clock pulses
    always @(posedge clk) begin
        fgap <= ftick ? 1 : fgap + 1;
        pgap <= ptick ? 1 : pgap + 1;
        if (ftick) fper <= fgap;
        if (ptick) pper <= pgap;
    end
    mpu_host host_u (.clk(clk), .rd_bus(rbus), .rd_oe(oe), .ce_n(ce_n), .rw(rw), .di(di), .wr_bus(wbus));
    lcd_command_and_address_logic #(.RC_DIV(RC_TB)) dut_u (.clk(clk), .srst(srst), .ce_n_pin(ce_n), .rw_pin(rw),
        .di_pin(di), .data_in_pin(wbus), .data_out(rbus), .data_oe(oe), .ext_clk_pin(ext_clk),
        .density_level(density), .booster_enable(boost), .osc_run(osc), .clk_source_rc(src),
        .pump_clk_sel(pump), .display_standby_bit(stby), .display_on_flag(on), .duty_18(duty),
        .word_length_flag(wlen), .counter_sel_page(csel), .count_up(up), .column_addr(col),
        .page_addr(page), .frame_tick(ftick), .pump_tick(ptick));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic d, input logic [7:0] b);
        host_u.access(1'b0, d, b, q);
    endtask
    task automatic rd(input logic d, input logic [7:0] e);
        host_u.access(1'b1, d, 8'h00, q);
        chk("rdata", {8'h00, e}, {8'h00, q});
    endtask
    task automatic end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #800000;
        bad_count++;
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 srst = 1'b0;
        repeat (3) @(posedge clk);
        chk("cfg", 16'h0227, cfg);
        chk("addr", 16'h0000, addr);
        rd(1'b0, 8'h43);
        wr(1'b0, 8'h7a);
        chk("density", 16'h0015, {density, boost});
        wr(1'b0, 8'h6f);
        chk("density", 16'h001e, {density, boost});
        wr(1'b0, 8'h60);
        wr(1'b0, 8'h10);
        chk("osc", 16'h0000, osc);
        wr(1'b0, 8'h11);
        chk("osc", 16'h0001, osc);
        wr(1'b0, 8'h21);
        chk("src", 16'h0001, src);
        wr(1'b0, 8'h02);
        chk("src", 16'h0001, src);
        wr(1'b0, 8'h20);
        chk("src", 16'h0000, src);
        for (int i = 0; i < 4; i++) begin
            wr(1'b0, 8'h40 + 8'(i));
            chk("pump", 16'(i), pump);
        end
        wr(1'b0, 8'h30);
        chk("cfg", 16'h02e7, cfg);
        wr(1'b0, 8'h0b);
        chk("duty", 16'h0003, {duty, wlen});
        wr(1'b0, 8'h81);
        wr(1'b0, 8'hd1);
        wr(1'b1, 8'haa);
        chk("addr", 16'h0000, addr);
        wr(1'b0, 8'h80);
        wr(1'b1, 8'hbb);
        chk("addr", 16'h0011, addr);
        rd(1'b0, 8'h40);
        rd(1'b1, 8'haa);
        chk("addr", 16'h0010, addr);
        wr(1'b0, 8'h83);
        wr(1'b0, 8'he9);
        wr(1'b1, 8'hcc);
        chk("addr", 16'h0010, addr);
        wr(1'b0, 8'h82);
        wr(1'b1, 8'hdd);
        chk("addr", 16'h0130, addr);
        wr(1'b0, 8'h08);
        wr(1'b0, 8'hed);
        wr(1'b0, 8'h83);
        wr(1'b1, 8'h11);
        chk("addr", 16'h0010, addr);
        wr(1'b0, 8'h82);
        wr(1'b1, 8'h22);
        chk("addr", 16'h01b0, addr);
        wr(1'b0, 8'h21);
        wr(1'b0, 8'h70);
        wr(1'b0, 8'h40);
        repeat (3200) @(posedge clk);
        chk("frame_period", 16'(384 * RC_TB), 16'(fper));
        chk("pump_period", 16'(2 * RC_TB), 16'(pper));
        wr(1'b0, 8'h09);
        repeat (3600) @(posedge clk);
        chk("frame_period", 16'(432 * RC_TB), 16'(fper));
        wr(1'b0, 8'h10);
        repeat (2000) @(posedge clk);
        chk("frame_stopped", 16'h0001, 16'(fgap > 1800));
        @(posedge clk) #1 srst = 1'b1;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        repeat (3) @(posedge clk);
        chk("cfg", 16'h0227, cfg);
        chk("addr", 16'h0000, addr);
        rd(1'b0, 8'h43);
        end_of_test;
    end
endmodule // lcd_command_and_address_logic_tb_top
